// ==== rxwake_consts.svh ====
// offsets, field positions, reset values and timing counts
`ifndef RXWAKE_CONSTS_SVH
`define RXWAKE_CONSTS_SVH
`define REG_CTRL_OFF        12'h000
`define REG_STATUS_OFF      12'h004
`define REG_DATA_OFF        12'h008
`define CTRL_SFD_EN_BIT     0
`define CTRL_RX_START_IRQ_ENABLE_BIT      1
`define CTRL_MPF_BIT        2
`define CTRL_SIZE_LSB       3
`define CTRL_STOP2_BIT      6
`define CTRL_SYNC_BIT       7
`define CTRL_RST_VAL        32'h0000_0018
`define STAT_RXC_BIT        0
`define STAT_TXC_BIT        1
`define STAT_START_BIT      2
`define STAT_WAKE_BIT       3
`define STAT_OSC_BIT        4
`define STAT_NINTH_BIT      5
`define OSC_START_NS        2000
`define CLK_PERIOD_NS       20
`define OSC_START_CYC       ((`OSC_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SIZE_9BIT           3'h7
`endif

// ==== rxwake_pkg.sv ====
// types for the receive wake and address filter block
package rxwake_pkg;
	typedef enum logic [1:0] {
		WK_SLEEP = 2'b00,
		WK_OSC   = 2'b01,
		WK_FRAME = 2'b10
	} wake_state_e;
	typedef logic [2:0] char_size_t;
endpackage

// ==== rxwake_osc_timer.sv ====
// oscillator start-up timer
module rxwake_osc_timer #(
	parameter int CYCLES = 100
) (
	// clock and control
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic ce_i,
	input  wire logic start_i,
	// status
	output logic      ready_o
);
	logic [15:0] cnt_r;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt_r   <= 16'h0000;
			ready_o <= 1'b0;
		end else if (ce_i) begin
			if (!start_i) begin
				cnt_r   <= 16'h0000;
				ready_o <= 1'b0;
			end else if (cnt_r == 16'(CYCLES - 1)) begin
				ready_o <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end
endmodule

// ==== rxwake_filter.sv ====
// start-frame wake logic and multi-processor address filter
// Functional notes
// RL1: start bit on rx line wakes device from power-down and standby
// RL2: falling edge in sleep powers oscillator and enables port clock
// RL3: detection works sync and async, only when its enable is set
// RL4: start interrupt raised at once on detection when enabled
// RL5: without start interrupt only oscillator and port clock run
// RL6: sync sender stays under clock/4 from idle, 500 kbps otherwise
// RL7: async sender from idle may use active-mode max baud rate
// RL8: normal speed wake-up baud error within tabulated limits
// RL9: double speed wake-up baud error within tabulated limits
// RL10: filter on drops every non-address frame before receive buffer
// RL11: transmitter ignores the filter bit
// RL12: frame type is first stop bit, or ninth bit for 9-bit frames
// RL13: frame type one means address, zero means data
// RL14: accepted address frame sets receive-complete like any frame
// RL15: master uses 9-bit frames, ninth bit marks address
// RL16: slave software reads address, clears filter if selected
// RL17: filter clear accepts all data; filter set ignores data
// RL18: slave sets filter again after the last data frame
// RL19: 5-8 bit multi-processor sender uses two stop bits
// RL20: transmitter and receiver share one character size setting
// RL21: software avoids read-modify-write on the filter bit
// RL22: only the first stop bit is evaluated
// RL23: detection disabled means no oscillator start or clock wake
`include "rxwake_consts.svh"
module rxwake_filter
	import rxwake_pkg::*;
#(
	parameter int OSC_CYCLES = `OSC_START_CYC
) (
	// clock, enable, reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        ce_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// serial line and power state
	input  wire logic        serial_rx_line_i,
	input  wire logic        deep_sleep_i,
	// frame from the assembler
	input  wire logic        frame_valid_i,
	input  wire logic [8:0]  frame_data_i,
	input  wire logic        first_stop_i,
	input  wire logic        frame_active_i,
	// transmitter side
	input  wire logic        tx_done_i,
	output logic      [2:0]  tx_char_size_o,
	output logic             tx_two_stop_o,
	// clock and wake control
	output logic             osc_enable_o,
	output logic             port_clk_enable_o,
	output logic             cpu_wake_o,
	output logic             rx_start_irq_o,
	output logic             rx_complete_irq_o
);
	logic [31:0]  ctrl_r;
	logic         rx_complete_flag_r;
	logic         tx_complete_flag_r;
	logic         start_seen_r;
	logic [8:0]   port_data_reg_r;
	logic         rx_ninth_bit_r;
	logic         rx_prev_r;
	wake_state_e  wake_r;
	logic         osc_ready;
	logic         start_det;
	logic         frame_type;
	logic         accept;
	logic         wr_en;
	logic         rd_en;
	// register decode, flag terms and status gathering
	localparam int STAT_USED = 6;
	logic         sel_ctrl;
	logic         sel_status;
	logic         sel_data;
	logic         status_wr;
	logic         data_rd;
	logic         rd_setup;
	logic         sleep_start;
	logic         rxc_set;
	logic         rxc_clr;
	logic         txc_set;
	logic         txc_clr;
	logic         start_set;
	logic         start_clr;
	logic [STAT_USED-1:0] status_bits;
	logic [31:0]  status_word;
	logic [31:0]  read_word;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		return a == o;
	endfunction

	// register select decode shared by clear and read paths; the control write decodes its own address
	assign sel_ctrl   = hit(paddr_i, `REG_CTRL_OFF);
	assign sel_status = hit(paddr_i, `REG_STATUS_OFF);
	assign sel_data   = hit(paddr_i, `REG_DATA_OFF);
	assign status_wr  = ce_i && wr_en && sel_status;
	assign data_rd    = ce_i && rd_en && sel_data;
	assign rd_setup   = ce_i && psel_i && !penable_i && !pwrite_i;

	wire logic        start_frame_detect_enable = ctrl_r[`CTRL_SFD_EN_BIT];
	wire logic        rx_start_irq_enable       = ctrl_r[`CTRL_RX_START_IRQ_ENABLE_BIT];
	wire logic        multiproc_filter_bit      = ctrl_r[`CTRL_MPF_BIT];
	wire char_size_t  char_size_code = ctrl_r[`CTRL_SIZE_LSB +: 3];

	assign wr_en     = psel_i && penable_i && pwrite_i;
	assign rd_en     = psel_i && penable_i && !pwrite_i;
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i
		&& !hit(paddr_i, `REG_CTRL_OFF)
		&& !hit(paddr_i, `REG_STATUS_OFF)
		&& !hit(paddr_i, `REG_DATA_OFF);

	// one shared size setting for both directions; the stop setting drives only the transmitter
	assign tx_char_size_o = char_size_code; // RL20
	assign tx_two_stop_o  = ctrl_r[`CTRL_STOP2_BIT]; // RL11

	// frame type: ninth bit for 9-bit frames, else first stop bit
	assign frame_type = (char_size_code == `SIZE_9BIT) ?
		frame_data_i[8] : first_stop_i; // RL12 RL22
	// address frames carry a one in the type bit
	assign accept = frame_valid_i
		&& (!multiproc_filter_bit || frame_type); // RL10 RL13 RL17

	// start detect is a falling edge on the line while enabled
	assign start_det = start_frame_detect_enable
		&& rx_prev_r && !serial_rx_line_i; // RL3 RL23

	// control register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_r <= `CTRL_RST_VAL;
		end else if (ce_i && wr_en && hit(paddr_i, `REG_CTRL_OFF)) begin
			ctrl_r <= {24'h000000, pwdata_i[7:0]};
		end
	end

	// line history for edge detection
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rx_prev_r <= 1'b1;
		end else if (ce_i) begin
			rx_prev_r <= serial_rx_line_i;
		end
	end

	// wake sequencer
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wake_r <= WK_SLEEP;
		end else if (ce_i) begin
			case (wake_r)
				WK_SLEEP: begin
					if (deep_sleep_i && start_det) begin
						wake_r <= WK_OSC; // RL1 RL2
					end
				end
				WK_OSC: begin
					if (osc_ready) begin
						wake_r <= WK_FRAME;
					end
				end
				WK_FRAME: begin
					if (frame_valid_i || !deep_sleep_i) begin
						wake_r <= WK_SLEEP; // RL5
					end
				end
				default: begin
					wake_r <= WK_SLEEP;
				end
			endcase
		end
	end

	rxwake_osc_timer #(
		.CYCLES (OSC_CYCLES)
	) u_osc_timer (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.ce_i    (ce_i),
		.start_i (wake_r != WK_SLEEP),
		.ready_o (osc_ready)
	);

	// start edge while asleep opens the wake window
	assign sleep_start = deep_sleep_i && start_det; // RL2

	// oscillator request: from the start edge to the end of the frame
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			osc_enable_o <= 1'b0;
		end else if (ce_i) begin
			osc_enable_o <= (wake_r != WK_SLEEP) || sleep_start; // RL2
		end
	end

	// port clock waits for the oscillator, then covers the frame
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			port_clk_enable_o <= 1'b0;
		end else if (ce_i) begin
			port_clk_enable_o <= (wake_r == WK_FRAME)
				|| (wake_r == WK_OSC && osc_ready)
				|| frame_active_i; // RL5
		end
	end

	// flag set and clear terms; a set in the clear cycle wins
	assign rxc_set   = accept; // RL14
	assign rxc_clr   = data_rd;
	assign txc_set   = tx_done_i;
	assign txc_clr   = status_wr && pwdata_i[`STAT_TXC_BIT];
	assign start_set = start_det; // RL4
	assign start_clr = status_wr && pwdata_i[`STAT_START_BIT];

	// start seen flag, write one to clear
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			start_seen_r <= 1'b0;
		end else if (ce_i) begin
			if (start_set) begin
				start_seen_r <= 1'b1;
			end else if (start_clr) begin
				start_seen_r <= 1'b0;
			end
		end
	end

	// receive buffer: only accepted frames are stored
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			port_data_reg_r <= 9'h000;
			rx_ninth_bit_r  <= 1'b0;
		end else if (ce_i && accept) begin
			port_data_reg_r <= frame_data_i; // RL10
			rx_ninth_bit_r  <= frame_type;
		end
	end

	// receive complete flag, cleared by reading the data word
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rx_complete_flag_r <= 1'b0;
		end else if (ce_i) begin
			if (rxc_set) begin
				rx_complete_flag_r <= 1'b1;
			end else if (rxc_clr) begin
				rx_complete_flag_r <= 1'b0;
			end
		end
	end

	// transmit complete flag, write one to clear
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tx_complete_flag_r <= 1'b0;
		end else if (ce_i) begin
			if (txc_set) begin
				tx_complete_flag_r <= 1'b1;
			end else if (txc_clr) begin
				tx_complete_flag_r <= 1'b0;
			end
		end
	end

	// start interrupt level
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rx_start_irq_o <= 1'b0;
		end else if (ce_i) begin
			rx_start_irq_o <= rx_start_irq_enable
				&& (start_seen_r || start_det); // RL4
		end
	end

	// receive complete interrupt level
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rx_complete_irq_o <= 1'b0;
		end else if (ce_i) begin
			rx_complete_irq_o <= rx_complete_flag_r || accept;
		end
	end

	// processor wake pulse: start interrupt or accepted frame
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cpu_wake_o <= 1'b0;
		end else if (ce_i) begin
			cpu_wake_o <= (rx_start_irq_enable && start_det)
				|| accept; // RL1 RL5
		end
	end

	// status flags gathered at their bit positions
	assign status_bits[`STAT_RXC_BIT]   = rx_complete_flag_r;
	assign status_bits[`STAT_TXC_BIT]   = tx_complete_flag_r;
	assign status_bits[`STAT_START_BIT] = start_seen_r;
	assign status_bits[`STAT_WAKE_BIT]  = wake_r != WK_SLEEP;
	assign status_bits[`STAT_OSC_BIT]   = osc_ready;
	assign status_bits[`STAT_NINTH_BIT] = rx_ninth_bit_r;

	// flags fill the low bits; the rest of the word reads zero
	for (genvar i = 0; i < 32; i++) begin : g_status
		if (i < STAT_USED) begin : g_flag
			assign status_word[i] = status_bits[i];
		end else begin : g_zero
			assign status_word[i] = 1'b0;
		end
	end

	// read mux over the decoded selects; unmapped reads zero
	always_comb begin
		read_word = 32'h0000_0000;
		if (sel_ctrl) begin
			read_word = ctrl_r;
		end else if (sel_status) begin
			read_word = status_word;
		end else if (sel_data) begin
			read_word = {23'h000000, port_data_reg_r};
		end
	end

	// read data captured in the setup cycle, held until the next read
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_o <= read_word;
		end
	end
endmodule

// ==== rxwake_filter_asserts.sv ====
// checker for the wake and address filter block
module rxwake_filter_asserts (
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic        ce_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        serial_rx_line_i,
	input wire logic        deep_sleep_i,
	input wire logic        frame_valid_i,
	input wire logic [8:0]  frame_data_i,
	input wire logic        first_stop_i,
	input wire logic [2:0]  tx_char_size_o,
	input wire logic        osc_enable_o,
	input wire logic        cpu_wake_o,
	input wire logic        rx_start_irq_o,
	input wire logic        rx_complete_irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] en_r;
	logic       wr;
	logic       kind;
	assign wr = ce_i & psel_i & penable_i & pwrite_i & (paddr_i == 12'h000);
	// frame type: ninth bit for 9-bit frames, else first stop
	assign kind = (tx_char_size_o == 3'h7) ? frame_data_i[8] : first_stop_i;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			en_r <= 3'h0;
		end else if (wr) begin
			en_r <= pwdata_i[2:0];
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence s_start;
		ce_i && deep_sleep_i && $fell(serial_rx_line_i);
	endsequence
	sequence s_frame;
		ce_i && frame_valid_i;
	endsequence
	a_wake_start: assert property (
		s_start ##0 en_r[0] |=> osc_enable_o) else $error("no wake");
	a_wake_off: assert property (
		s_start ##0 !en_r[0] && !osc_enable_o |=> !osc_enable_o)
		else $error("wake while off");
	a_start_irq: assert property (
		s_start ##0 en_r[0] && en_r[1] |=> rx_start_irq_o && cpu_wake_o)
		else $error("no start irq");
	a_quiet_wake: assert property (
		s_start ##0 en_r == 3'h1 && !frame_valid_i |=> !cpu_wake_o)
		else $error("early cpu wake");
	a_drop_data: assert property (
		s_frame ##0 en_r[2] && !kind && !rx_complete_irq_o
		|=> !rx_complete_irq_o) else $error("data not dropped");
	a_take_addr: assert property (
		s_frame ##0 kind |=> rx_complete_irq_o) else $error("addr lost");
	a_take_open: assert property (
		s_frame ##0 !en_r[2] |=> rx_complete_irq_o) else $error("data lost");
	a_size_shared: assert property (
		wr |=> tx_char_size_o == $past(pwdata_i[5:3]))
		else $error("size not shared");
endmodule
bind rxwake_filter rxwake_filter_asserts chk_i (.clk_i(clk_i),
	.srst_i(srst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.serial_rx_line_i(serial_rx_line_i), .deep_sleep_i(deep_sleep_i),
	.frame_valid_i(frame_valid_i), .frame_data_i(frame_data_i),
	.first_stop_i(first_stop_i), .tx_char_size_o(tx_char_size_o),
	.osc_enable_o(osc_enable_o), .cpu_wake_o(cpu_wake_o),
	.rx_start_irq_o(rx_start_irq_o), .rx_complete_irq_o(rx_complete_irq_o));

// ==== rxwake_master_src.sv ====
// master transmitter model: start edge then assembled frame
module rxwake_master_src (
	// clock
	input  wire logic       clk_i,
	// line and frame
	output logic            line_o,
	output logic            valid_o,
	output logic      [8:0] data_o,
	output logic            stop_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		line_o = 1'b1;
		valid_o = 1'b0;
		data_o = 9'h000;
		stop_o = 1'b0;
	end
	task automatic send(input logic [8:0] d, input logic s, input int n);
		@(posedge clk_i);
		line_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		valid_o <= 1'b1;
		data_o <= d;
		stop_o <= s;
		@(posedge clk_i);
		valid_o <= 1'b0;
		line_o <= 1'b1;
		// released fields show the inverse
		data_o <= ~d;
		stop_o <= ~s;
	endtask
endmodule

// ==== uart_rx_wake_and_address_filter_bench.sv ====
// self-checking bench for the wake and address filter
module uart_rx_wake_and_address_filter_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0;
	logic        pwr = 1'b0, sleep = 1'b0, pready, perr, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        line, fv, stop, two, osc, pclk, sirq, cirq, wk;
	int          wakes = 0;
	logic [8:0]  fdata;
	logic [2:0]  size;
	int          failures = 0, cmp_count = 0, cyc = 0;
	rxwake_filter #(.OSC_CYCLES(4)) dut (.clk_i(clk), .srst_i(srst),
		.ce_i(1'b1), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(perr), .serial_rx_line_i(line),
		.deep_sleep_i(sleep), .frame_valid_i(fv), .frame_data_i(fdata),
		.first_stop_i(stop), .frame_active_i(1'b0), .tx_done_i(1'b0),
		.tx_char_size_o(size), .tx_two_stop_o(two), .osc_enable_o(osc),
		.port_clk_enable_o(pclk), .cpu_wake_o(wk), .rx_start_irq_o(sirq),
		.rx_complete_irq_o(cirq));
	rxwake_master_src src (.clk_i(clk), .line_o(line), .valid_o(fv),
		.data_o(fdata), .stop_o(stop));
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		if (wk === 1'b1) begin
			wakes <= wakes + 1;
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic t_regs();
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0000_0018);
		chk(size, 32'h3);
		apb(1'b0, 12'h00C, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		$display("register test done");
	endtask
	task automatic t_wake(input logic [31:0] c, input logic eo,
		input logic ei);
		int w0;
		w0 = wakes;
		apb(1'b0, 12'h008, 32'h0);
		apb(1'b1, 12'h000, c);
		fork
			src.send(9'h0A5, 1'b1, 16);
			begin
				repeat (4) @(posedge clk);
				chk(osc, eo);
				chk(sirq, ei);
				repeat (10) @(posedge clk);
				chk(pclk, eo);
			end
		join
		repeat (2) @(posedge clk);
		chk(cirq, 1'b1);
		chk(wakes - w0, 32'(1 + ei));
		$display("wake test done");
	endtask
	task automatic frame(input logic [8:0] d, input logic s, input logic e);
		apb(1'b0, 12'h008, 32'h0);
		src.send(d, s, 3);
		@(posedge clk);
		chk(cirq, e);
	endtask
	task automatic t_filter();
		apb(1'b1, 12'h000, 32'h0000_003C);
		chk(size, 32'h7);
		frame(9'h033, 1'b1, 1'b0);
		frame(9'h1A5, 1'b0, 1'b1);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h1A5);
		apb(1'b1, 12'h000, 32'h0000_0038);
		frame(9'h066, 1'b0, 1'b1);
		apb(1'b1, 12'h000, 32'h0000_005C);
		chk(two, 1'b1);
		frame(9'h155, 1'b0, 1'b0);
		frame(9'h077, 1'b1, 1'b1);
		$display("filter test done");
	endtask
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_regs();
		sleep <= 1'b1;
		t_wake(32'h0000_0018, 1'b0, 1'b0);
		t_wake(32'h0000_0019, 1'b1, 1'b0);
		t_wake(32'h0000_001B, 1'b1, 1'b1);
		sleep <= 1'b0;
		t_filter();
		summarize();
	end
endmodule
